/* File: mtu_pkg.sv */
// Constants, field layout and modes of the multi-timer unit.
// Overview of operation
// - Timer X write with write-control 0 loads counter and reload latch together.
// - Timer X write with write-control 1 loads only the latch; underflow reloads.
// - Event pin A request follows the edge chosen by its edge switch bit.
// - Enabled real-time port copies its two data bits to pins on X underflow.
// - Real-time control going 0 to 1 drives data to pins at once.
// - Data changed while enabled waits for the next timer X underflow.
// - Timer Y has four modes; timer mode counts the divided oscillator.
// - Count source is main oscillator over 16, sub oscillator over 16 in low speed.
// - Period mode: selected edge on pin B requests and reloads timer Y.
// - Value before an edge reload is held until timer Y is read once.
// - Event mode: timer Y counts pin B edges instead of the divided clock.
// - High/low width mode: both edges of pin B request and reload.
// - Otherwise pin B request edge follows its edge switch bit.
// - Each 8-bit timer selects its source; latch unaffected by the change.
// - Timer 1 underflow can clock timer 2 or timer 3.
// - Timer 2 write with write-control 0 loads counter and latch together.
// - Timer 2 write with write-control 1 loads only the latch.
// - Enabled toggle output inverts on every timer 2 underflow.
// - Timers count down, underflow after zero, reload, and set a request bit.
// - Pulse output mode toggles event pin A on each timer X underflow.
// - Width mode counts while pin A is high (switch 0) or low (switch 1).
package mtu_pkg;
  localparam logic [5:0] IDX_TXL = 6'h20;
  localparam logic [5:0] IDX_TXH = 6'h21;
  localparam logic [5:0] IDX_TYL = 6'h22;
  localparam logic [5:0] IDX_TYH = 6'h23;
  localparam logic [5:0] IDX_T1 = 6'h24;
  localparam logic [5:0] IDX_T2 = 6'h25;
  localparam logic [5:0] IDX_T3 = 6'h26;
  localparam logic [5:0] IDX_XMODE = 6'h27;
  localparam logic [5:0] IDX_YMODE = 6'h28;
  localparam logic [5:0] IDX_T123 = 6'h29;
  localparam logic [5:0] IDX_CLKSEL = 6'h3B;
  localparam logic [5:0] IDX_REQ = 6'h3C;
  localparam int XM_WC = 2;
  localparam int XM_RTP0 = 3;
  localparam int XM_RTP1 = 4;
  localparam int XM_RTPEN = 5;
  localparam int M_EDGE = 6;
  localparam int M_STOP = 7;
  localparam int T_T2WC = 0;
  localparam int T_T1SRC = 1;
  localparam int T_T2SRC = 2;
  localparam int T_T3SRC = 3;
  localparam int T_T2TOG = 4;
  localparam int CK_LOW = 0;
  localparam int RQ_X = 0;
  localparam int RQ_Y = 1;
  localparam int RQ_T1 = 2;
  localparam int RQ_T2 = 3;
  localparam int RQ_T3 = 4;
  localparam int RQ_A = 5;
  localparam int RQ_B = 6;
  localparam int RQ_W = 7;
  localparam logic [15:0] RST_T16 = 16'hFFFF;
  localparam logic [7:0] RST_T1 = 8'hFF;
  localparam logic [7:0] RST_T2 = 8'h01;
  localparam logic [7:0] RST_T3 = 8'hFF;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int OSC_DIV = 16;
  localparam logic [3:0] DIV_LAST = 4'(OSC_DIV - 1);
  typedef enum logic [1:0] {XM_TIMER, XM_PULSE, XM_EVENT, XM_PWIDTH} mtu_xmode_t;
  typedef enum logic [1:0] {YM_TIMER, YM_PERIOD, YM_EVENT, YM_HL} mtu_ymode_t;
endpackage

/* File: mtu_top.sv */
// Multi-timer unit: two 16-bit and three 8-bit down counters on an Avalon-MM slave.
`timescale 1ns/1ns
module mtu_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic main_osc_in_i,
  input wire logic sub_osc_in_i,
  input wire logic event_pin_a_i,
  output logic event_pin_a_o,
  output logic event_pin_a_oe_o,
  input wire logic event_pin_b_i,
  output logic timer2_toggle_out_o,
  output logic realtime_out_bit0_o,
  output logic realtime_out_bit1_o,
  output logic [6:0] irq_req_o
);
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  function automatic logic is_uf(input logic tick, input logic [15:0] cnt);
    is_uf = tick && (cnt == 16'h0000);
  endfunction

  logic ack_ff;
  logic [31:0] rdata_ff;
  logic main_q_ff, sub_q_ff, pa_q_ff, pb_q_ff;
  logic [3:0] main_div_ff, sub_div_ff;
  logic [7:0] xmode_ff, ymode_ff, t123_ff, clksel_ff;
  logic [15:0] tx_ff, tx_lat_ff, ty_ff, ty_lat_ff, hold_ff;
  logic hold_v_ff;
  logic [7:0] wbuf_ff, rbuf_ff;
  logic [7:0] t1_ff, t1_lat_ff, t2_ff, t2_lat_ff, t3_ff, t3_lat_ff;
  logic tog_ff, pa_out_ff;
  logic [1:0] rtp_ff;
  logic [6:0] req_ff;
  logic [5:0] idx;
  logic [7:0] wd, rd_val;
  logic rd_start, rd_done, wr_done;
  logic main_tick, sub_tick, src_tick;
  logic pa_rise, pa_fall, pb_rise, pb_fall, a_edge, b_edge, y_edge_evt;
  logic x_tick, x_uf, y_tick, y_uf, t1_tick, t1_uf, t2_tick, t2_uf, t3_tick, t3_uf;
  logic wr_txh, wr_tyh, wr_xmode;
  logic [15:0] wval;
  mtu_pkg::mtu_xmode_t xmode;
  mtu_pkg::mtu_ymode_t ymode;

  // A one-cycle wait lets the hold release happen at the completing edge; the low-byte read buffer loads at the first edge.
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
  assign rd_start = avs_read_i && !ack_ff;
  assign rd_done = avs_read_i && ack_ff;
  assign wr_done = avs_write_i && ack_ff && avs_byteenable_i[0];
  assign idx = avs_address_i[7:2];
  assign wd = avs_writedata_i[7:0];
  assign wval = {wd, wbuf_ff};
  assign wr_txh = wr_done && (idx == mtu_pkg::IDX_TXH);
  assign wr_tyh = wr_done && (idx == mtu_pkg::IDX_TYH);
  assign wr_xmode = wr_done && (idx == mtu_pkg::IDX_XMODE);
  assign avs_readdata_o = rdata_ff;
  assign xmode = mtu_pkg::mtu_xmode_t'(xmode_ff[1:0]);
  assign ymode = mtu_pkg::mtu_ymode_t'(ymode_ff[1:0]);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
    end
  end

  // Prescalers divide each oscillator input by sixteen.
  assign main_tick = main_osc_in_i && !main_q_ff && (main_div_ff == mtu_pkg::DIV_LAST);
  assign sub_tick = sub_osc_in_i && !sub_q_ff && (sub_div_ff == mtu_pkg::DIV_LAST);
  assign src_tick = clksel_ff[mtu_pkg::CK_LOW] ? sub_tick : main_tick;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      main_q_ff <= 1'b0;
      sub_q_ff <= 1'b0;
      pa_q_ff <= 1'b0;
      pb_q_ff <= 1'b0;
      main_div_ff <= 4'h0;
      sub_div_ff <= 4'h0;
    end else begin
      main_q_ff <= main_osc_in_i;
      sub_q_ff <= sub_osc_in_i;
      pa_q_ff <= event_pin_a_i;
      pb_q_ff <= event_pin_b_i;
      if (main_osc_in_i && !main_q_ff) begin
        main_div_ff <= main_div_ff + 4'h1;
      end
      if (sub_osc_in_i && !sub_q_ff) begin
        sub_div_ff <= sub_div_ff + 4'h1;
      end
    end
  end

  assign pa_rise = event_pin_a_i && !pa_q_ff;
  assign pa_fall = !event_pin_a_i && pa_q_ff;
  assign pb_rise = event_pin_b_i && !pb_q_ff;
  assign pb_fall = !event_pin_b_i && pb_q_ff;
  assign a_edge = xmode_ff[mtu_pkg::M_EDGE] ? pa_fall : pa_rise;
  assign b_edge = (ymode == mtu_pkg::YM_HL) ? (pb_rise || pb_fall) :
                  (ymode_ff[mtu_pkg::M_EDGE] ? pb_fall : pb_rise);
  assign y_edge_evt = ((ymode == mtu_pkg::YM_PERIOD) || (ymode == mtu_pkg::YM_HL)) && b_edge;

  always_comb begin
    case (xmode)
      mtu_pkg::XM_EVENT: x_tick = a_edge;
      mtu_pkg::XM_PWIDTH: x_tick = src_tick && (event_pin_a_i == !xmode_ff[mtu_pkg::M_EDGE]);
      default: x_tick = src_tick;
    endcase
    if (xmode_ff[mtu_pkg::M_STOP]) begin
      x_tick = 1'b0;
    end
  end

  // Event mode counts pin B edges; every other mode counts the divided clock.
  assign y_tick = !ymode_ff[mtu_pkg::M_STOP] &&
                  ((ymode == mtu_pkg::YM_EVENT) ? b_edge : src_tick);
  assign x_uf = is_uf(x_tick, tx_ff);
  assign y_uf = is_uf(y_tick, ty_ff);
  assign t1_tick = t123_ff[mtu_pkg::T_T1SRC] ? sub_tick : src_tick;
  assign t1_uf = is_uf(t1_tick, {8'h00, t1_ff});
  assign t2_tick = t123_ff[mtu_pkg::T_T2SRC] ? t1_uf : src_tick;
  assign t2_uf = is_uf(t2_tick, {8'h00, t2_ff});
  assign t3_tick = t123_ff[mtu_pkg::T_T3SRC] ? t1_uf : src_tick;
  assign t3_uf = is_uf(t3_tick, {8'h00, t3_ff});

  // Mode and control registers.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xmode_ff <= mtu_pkg::RST_REG;
      ymode_ff <= mtu_pkg::RST_REG;
      t123_ff <= mtu_pkg::RST_REG;
      clksel_ff <= mtu_pkg::RST_REG;
    end else if (wr_done) begin
      if (idx == mtu_pkg::IDX_XMODE) begin
        xmode_ff <= wd;
      end else if (idx == mtu_pkg::IDX_YMODE) begin
        ymode_ff <= wd;
      end else if (idx == mtu_pkg::IDX_T123) begin
        t123_ff <= wd;
      end else if (idx == mtu_pkg::IDX_CLKSEL) begin
        clksel_ff <= {7'h00, wd[mtu_pkg::CK_LOW]};
      end
    end
  end

  // Low byte is staged; the high-byte access moves the whole word.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wbuf_ff <= 8'h00;
      rbuf_ff <= 8'h00;
    end else begin
      if (wr_done && ((idx == mtu_pkg::IDX_TXL) || (idx == mtu_pkg::IDX_TYL))) begin
        wbuf_ff <= wd;
      end
      if (rd_start && (idx == mtu_pkg::IDX_TXH)) begin
        rbuf_ff <= tx_ff[7:0];
      end else if (rd_start && (idx == mtu_pkg::IDX_TYH)) begin
        rbuf_ff <= hold_v_ff ? hold_ff[7:0] : ty_ff[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_ff <= mtu_pkg::RST_T16;
      tx_lat_ff <= mtu_pkg::RST_T16;
    end else begin
      if (wr_txh) begin
        tx_lat_ff <= wval;
      end
      if (wr_txh && !xmode_ff[mtu_pkg::XM_WC]) begin
        tx_ff <= wval;
      end else if (x_uf) begin
        tx_ff <= tx_lat_ff;
      end else if (x_tick) begin
        tx_ff <= tx_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ty_ff <= mtu_pkg::RST_T16;
      ty_lat_ff <= mtu_pkg::RST_T16;
      hold_ff <= 16'h0000;
      hold_v_ff <= 1'b0;
    end else begin
      if (wr_tyh) begin
        ty_lat_ff <= wval;
        ty_ff <= wval;
      end else if (y_edge_evt || y_uf) begin
        ty_ff <= ty_lat_ff;
      end else if (y_tick) begin
        ty_ff <= ty_ff - 16'h0001;
      end
      // A new capture wins over the read that would release the old one.
      if (y_edge_evt && !wr_tyh) begin
        hold_ff <= ty_ff;
        hold_v_ff <= 1'b1;
      end else if (rd_done && (idx == mtu_pkg::IDX_TYL)) begin
        hold_v_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      t1_ff <= mtu_pkg::RST_T1;
      t1_lat_ff <= mtu_pkg::RST_T1;
      t2_ff <= mtu_pkg::RST_T2;
      t2_lat_ff <= mtu_pkg::RST_T2;
      t3_ff <= mtu_pkg::RST_T3;
      t3_lat_ff <= mtu_pkg::RST_T3;
    end else begin
      if (wr_done && (idx == mtu_pkg::IDX_T1)) begin
        t1_ff <= wd;
        t1_lat_ff <= wd;
      end else if (t1_uf) begin
        t1_ff <= t1_lat_ff;
      end else if (t1_tick) begin
        t1_ff <= t1_ff - 8'h01;
      end
      if (wr_done && (idx == mtu_pkg::IDX_T2)) begin
        t2_lat_ff <= wd;
      end
      if (wr_done && (idx == mtu_pkg::IDX_T2) && !t123_ff[mtu_pkg::T_T2WC]) begin
        t2_ff <= wd;
      end else if (t2_uf) begin
        t2_ff <= t2_lat_ff;
      end else if (t2_tick) begin
        t2_ff <= t2_ff - 8'h01;
      end
      if (wr_done && (idx == mtu_pkg::IDX_T3)) begin
        t3_ff <= wd;
        t3_lat_ff <= wd;
      end else if (t3_uf) begin
        t3_ff <= t3_lat_ff;
      end else if (t3_tick) begin
        t3_ff <= t3_ff - 8'h01;
      end
    end
  end

  // Pin outputs: pulse output, toggle output and the real-time port.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pa_out_ff <= 1'b0;
      tog_ff <= 1'b0;
      rtp_ff <= 2'b00;
    end else begin
      if (x_uf && (xmode == mtu_pkg::XM_PULSE)) begin
        pa_out_ff <= !pa_out_ff;
      end
      if (t2_uf && t123_ff[mtu_pkg::T_T2TOG]) begin
        tog_ff <= !tog_ff;
      end
      if (wr_xmode && !xmode_ff[mtu_pkg::XM_RTPEN] && wd[mtu_pkg::XM_RTPEN]) begin
        rtp_ff <= {wd[mtu_pkg::XM_RTP1], wd[mtu_pkg::XM_RTP0]};
      end else if (x_uf && xmode_ff[mtu_pkg::XM_RTPEN]) begin
        rtp_ff <= {xmode_ff[mtu_pkg::XM_RTP1], xmode_ff[mtu_pkg::XM_RTP0]};
      end
    end
  end

  assign event_pin_a_o = pa_out_ff;
  assign event_pin_a_oe_o = (xmode == mtu_pkg::XM_PULSE);
  assign timer2_toggle_out_o = tog_ff;
  assign realtime_out_bit0_o = rtp_ff[0];
  assign realtime_out_bit1_o = rtp_ff[1];
  assign irq_req_o = req_ff;

  // Request bits clear by writing one; a same-cycle event keeps the bit set.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_ff <= 7'h00;
    end else begin
      req_ff <= (req_ff & ~((wr_done && (idx == mtu_pkg::IDX_REQ)) ? wd[6:0] : 7'h00)) |
                {b_edge, a_edge, t3_uf, t2_uf, t1_uf, y_uf, x_uf};
    end
  end

  always_comb begin
    if (idx == mtu_pkg::IDX_TXL) begin
      rd_val = rbuf_ff;
    end else if (idx == mtu_pkg::IDX_TXH) begin
      rd_val = tx_ff[15:8];
    end else if (idx == mtu_pkg::IDX_TYL) begin
      rd_val = rbuf_ff;
    end else if (idx == mtu_pkg::IDX_TYH) begin
      rd_val = hold_v_ff ? hold_ff[15:8] : ty_ff[15:8];
    end else if (idx == mtu_pkg::IDX_T1) begin
      rd_val = t1_ff;
    end else if (idx == mtu_pkg::IDX_T2) begin
      rd_val = t2_ff;
    end else if (idx == mtu_pkg::IDX_T3) begin
      rd_val = t3_ff;
    end else if (idx == mtu_pkg::IDX_XMODE) begin
      rd_val = xmode_ff;
    end else if (idx == mtu_pkg::IDX_YMODE) begin
      rd_val = ymode_ff;
    end else if (idx == mtu_pkg::IDX_T123) begin
      rd_val = t123_ff;
    end else if (idx == mtu_pkg::IDX_CLKSEL) begin
      rd_val = clksel_ff;
    end else if (idx == mtu_pkg::IDX_REQ) begin
      rd_val = {1'b0, req_ff};
    end else begin
      rd_val = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_start) begin
      rdata_ff <= {24'h000000, rd_val};
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence s_x_reload;
    (tx_ff == $past(tx_lat_ff)) && req_ff[mtu_pkg::RQ_X];
  endsequence
  sequence s_bus_done;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence

  property p_x_direct;
    wr_txh && !xmode_ff[mtu_pkg::XM_WC] |=> (tx_ff == $past(wval)) && (tx_lat_ff == $past(wval));
  endproperty
  a_x_direct: assert property (p_x_direct) else $error("timer X direct write lost");
  property p_x_latch_only;
    wr_txh && xmode_ff[mtu_pkg::XM_WC] && !x_tick |=> $stable(tx_ff) && (tx_lat_ff == $past(wval));
  endproperty
  a_x_latch_only: assert property (p_x_latch_only) else $error("latch-only write moved timer X");
  property p_x_reload;
    x_uf && !wr_txh |=> s_x_reload;
  endproperty
  a_x_reload: assert property (p_x_reload) else $error("timer X underflow not reloaded");
  property p_rtp_uf;
    x_uf && xmode_ff[mtu_pkg::XM_RTPEN] && !wr_xmode |=>
      rtp_ff == $past({xmode_ff[mtu_pkg::XM_RTP1], xmode_ff[mtu_pkg::XM_RTP0]});
  endproperty
  a_rtp_uf: assert property (p_rtp_uf) else $error("real-time data not output");
  property p_rtp_now;
    wr_xmode && !xmode_ff[mtu_pkg::XM_RTPEN] && wd[mtu_pkg::XM_RTPEN] |=>
      rtp_ff == $past({wd[mtu_pkg::XM_RTP1], wd[mtu_pkg::XM_RTP0]});
  endproperty
  a_rtp_now: assert property (p_rtp_now) else $error("real-time enable did not output");
  property p_rtp_wait;
    xmode_ff[mtu_pkg::XM_RTPEN] && !x_uf |=> $stable(rtp_ff);
  endproperty
  a_rtp_wait: assert property (p_rtp_wait) else $error("real-time pins moved early");
  property p_y_hold;
    y_edge_evt && !wr_tyh |=> hold_v_ff && (hold_ff == $past(ty_ff)) && (ty_ff == $past(ty_lat_ff));
  endproperty
  a_y_hold: assert property (p_y_hold) else $error("timer Y capture wrong");
  property p_hl_both;
    (ymode == mtu_pkg::YM_HL) && (pb_rise || pb_fall) |=> req_ff[mtu_pkg::RQ_B];
  endproperty
  a_hl_both: assert property (p_hl_both) else $error("pin B edge missed");
  property p_t2_tog;
    t2_uf && t123_ff[mtu_pkg::T_T2TOG] |=> tog_ff != $past(tog_ff);
  endproperty
  a_t2_tog: assert property (p_t2_tog) else $error("toggle output not inverted");
  property p_t1_chain;
    t1_uf && t123_ff[mtu_pkg::T_T2SRC] && !wr_done && (t2_ff != 8'h00) |=> t2_ff == $past(t2_ff) - 8'h01;
  endproperty
  a_t1_chain: assert property (p_t1_chain) else $error("timer 2 not clocked by timer 1");
  property p_bus;
    (avs_read_i || avs_write_i) && !ack_ff |-> s_bus_done;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer not in two cycles");
endmodule

/* File: mtu_pins_model.sv */
// Far-side model: oscillator sources and the event pin levels seen by the timer unit.
`timescale 1ns/1ns
module mtu_pins_model (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic main_run_i,
  input wire logic sub_run_i,
  input wire logic pin_a_lvl_i,
  input wire logic pin_b_lvl_i,
  input wire logic pin_a_drv_i,
  input wire logic pin_a_oe_i,
  output logic main_osc_o,
  output logic sub_osc_o,
  output logic pin_a_o,
  output logic pin_b_o
);
  logic [1:0] sub_cnt_ff;
  // Oscillators stand still while stopped so that a halted timer keeps its value.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      main_osc_o <= 1'b0;
    end else if (main_run_i) begin
      main_osc_o <= ~main_osc_o;
    end
  end
  // The sub oscillator is four times slower than the main one.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sub_cnt_ff <= 2'h0;
      sub_osc_o <= 1'b0;
    end else if (sub_run_i) begin
      sub_cnt_ff <= sub_cnt_ff + 2'h1;
      if (sub_cnt_ff == 2'h3) begin
        sub_osc_o <= ~sub_osc_o;
      end
    end
  end
  // Pin A is shared: the unit's driver wins while its enable is high.
  assign pin_a_o = pin_a_oe_i ? pin_a_drv_i : pin_a_lvl_i;
  assign pin_b_o = pin_b_lvl_i;
endmodule

/* File: multi_timer_unit_xy_and_8bit_test.sv */
// Self-checking testbench of the multi-timer unit.
`timescale 1ns/1ns
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_total++; $display("mismatch at %0t: %s", $time, m); end end
module multi_timer_unit_xy_and_8bit_test;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic main_osc, sub_osc, pin_a, pin_b, pin_a_drv, pin_a_oe;
  logic main_run = 1'b0;
  logic sub_run = 1'b0;
  logic pin_a_lvl = 1'b0;
  logic pin_b_lvl = 1'b0;
  logic tog_out, rt0, rt1;
  logic [6:0] irq;
  int err_total = 0;
  int checked = 0;
  logic [7:0] q, a, b;
  logic [15:0] r16, v, w, h;
  logic [5:0] ridx [7] = '{mtu_pkg::IDX_T1, mtu_pkg::IDX_T2, mtu_pkg::IDX_T3,
    mtu_pkg::IDX_XMODE, mtu_pkg::IDX_YMODE, mtu_pkg::IDX_T123, 6'h30};
  logic [7:0] rexp [7] = '{mtu_pkg::RST_T1, mtu_pkg::RST_T2, mtu_pkg::RST_T3,
    mtu_pkg::RST_REG, mtu_pkg::RST_REG, mtu_pkg::RST_REG, 8'h00};
  logic [7:0] bmode [4] = '{8'h01, 8'h41, 8'h03, 8'h43};

  mtu_top dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .main_osc_in_i(main_osc), .sub_osc_in_i(sub_osc),
    .event_pin_a_i(pin_a), .event_pin_a_o(pin_a_drv), .event_pin_a_oe_o(pin_a_oe),
    .event_pin_b_i(pin_b), .timer2_toggle_out_o(tog_out), .realtime_out_bit0_o(rt0),
    .realtime_out_bit1_o(rt1), .irq_req_o(irq));

  mtu_pins_model pins_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .main_run_i(main_run),
    .sub_run_i(sub_run), .pin_a_lvl_i(pin_a_lvl), .pin_b_lvl_i(pin_b_lvl),
    .pin_a_drv_i(pin_a_drv), .pin_a_oe_i(pin_a_oe), .main_osc_o(main_osc),
    .sub_osc_o(sub_osc), .pin_a_o(pin_a), .pin_b_o(pin_b));

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Expected real-time pin pair for a mode value.
  function automatic logic [1:0] rtp_pins(input logic [7:0] m);
    return {m[mtu_pkg::XM_RTP1], m[mtu_pkg::XM_RTP0]};
  endfunction

  // Whether an edge of the given direction raises the pin request.
  function automatic logic edge_hit(input logic both, input logic sw, input logic rising);
    return both | (rising ^ sw);
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One bus transfer; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= {24'h000000, d};
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      $display("mismatch at %0t: bus wait too long", $time);
      print_verdict();
    end
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr16(input logic [5:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d[7:0]);
    bus(1'b1, idx + 6'h01, d[15:8]);
  endtask

  task automatic rd16(input logic [5:0] idx);
    bus(1'b0, idx + 6'h01, 8'h00);
    r16[15:8] = q;
    bus(1'b0, idx, 8'h00);
    r16[7:0] = q;
  endtask

  task automatic settle();
    repeat (3) @(negedge clk_sys_i);
  endtask

  task automatic wait_irq(input int bit_i, input int lim);
    int n;
    n = 0;
    while (irq[bit_i] !== 1'b1 && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("mismatch at %0t: request bit %0d never set", $time, bit_i);
      print_verdict();
    end
  endtask

  task automatic set_pin(input logic on_b, input logic lvl);
    @(posedge clk_sys_i);
    if (on_b) pin_b_lvl <= lvl;
    else pin_a_lvl <= lvl;
    settle();
  endtask

  // Edge request check for one pin under one mode value.
  task automatic edge_case(input logic on_b, input logic [7:0] m);
    logic both;
    int rb;
    both = on_b && (m[1:0] == 2'h3);
    rb = on_b ? mtu_pkg::RQ_B : mtu_pkg::RQ_A;
    bus(1'b1, on_b ? mtu_pkg::IDX_YMODE : mtu_pkg::IDX_XMODE, m);
    set_pin(on_b, 1'b0);
    bus(1'b1, mtu_pkg::IDX_REQ, 8'hFF);
    set_pin(on_b, 1'b1);
    `CHK(irq[rb], edge_hit(both, m[mtu_pkg::M_EDGE], 1'b1), "rising edge request")
    bus(1'b1, mtu_pkg::IDX_REQ, 8'hFF);
    set_pin(on_b, 1'b0);
    `CHK(irq[rb], edge_hit(both, m[mtu_pkg::M_EDGE], 1'b0), "falling edge request")
  endtask

  initial begin
    #(50 * 20000);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(32'h04D0));
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd16(mtu_pkg::IDX_TXL);
    `CHK(r16, mtu_pkg::RST_T16, "timer X reset value")
    rd16(mtu_pkg::IDX_TYL);
    `CHK(r16, mtu_pkg::RST_T16, "timer Y reset value")
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ridx[i], 8'h00);
      `CHK(q, rexp[i], "reset value or unmapped read")
    end
    $display("test reset done");
    v = 16'h0002 + 16'($urandom % 4);
    w = 16'h0100 + 16'($urandom % 256);
    bus(1'b1, mtu_pkg::IDX_CLKSEL, 8'h01);
    bus(1'b1, mtu_pkg::IDX_XMODE, 8'h00);
    wr16(mtu_pkg::IDX_TXL, v);
    rd16(mtu_pkg::IDX_TXL);
    `CHK(r16, v, "timer X direct load")
    bus(1'b1, mtu_pkg::IDX_XMODE, 8'h2C);
    settle();
    `CHK({rt1, rt0}, rtp_pins(8'h2C), "real-time data on enable")
    bus(1'b1, mtu_pkg::IDX_XMODE, 8'h34);
    settle();
    `CHK({rt1, rt0}, rtp_pins(8'h2C), "real-time data held until underflow")
    // The latch is rewritten while the counter is frozen, so no underflow can collide.
    wr16(mtu_pkg::IDX_TXL, w);
    rd16(mtu_pkg::IDX_TXL);
    `CHK(r16, v, "latch-only write keeps counter")
    bus(1'b1, mtu_pkg::IDX_REQ, 8'hFF);
    @(posedge clk_sys_i);
    sub_run <= 1'b1;
    wait_irq(mtu_pkg::RQ_X, 3000);
    sub_run <= 1'b0;
    rd16(mtu_pkg::IDX_TXL);
    `CHK(r16, w, "underflow reloads latch")
    `CHK({rt1, rt0}, rtp_pins(8'h34), "real-time data at underflow")
    $display("test timer X done");
    a = 8'h01 + 8'($urandom % 4);
    b = 8'h10 + 8'($urandom % 48);
    bus(1'b1, mtu_pkg::IDX_CLKSEL, 8'h00);
    bus(1'b1, mtu_pkg::IDX_T123, 8'h00);
    bus(1'b1, mtu_pkg::IDX_T2, a);
    bus(1'b0, mtu_pkg::IDX_T2, 8'h00);
    `CHK(q, a, "timer 2 direct load")
    bus(1'b1, mtu_pkg::IDX_T123, 8'h11);
    bus(1'b1, mtu_pkg::IDX_T2, b);
    bus(1'b0, mtu_pkg::IDX_T2, 8'h00);
    `CHK(q, a, "timer 2 latch-only write")
    `CHK(tog_out, 1'b0, "toggle output idle")
    bus(1'b1, mtu_pkg::IDX_REQ, 8'hFF);
    @(posedge clk_sys_i);
    main_run <= 1'b1;
    wait_irq(mtu_pkg::RQ_T2, 1000);
    main_run <= 1'b0;
    settle();
    bus(1'b0, mtu_pkg::IDX_T2, 8'h00);
    `CHK(q, b, "timer 2 reload after underflow")
    `CHK(tog_out, 1'b1, "toggle output inverted")
    $display("test timer 2 done");
    edge_case(1'b0, 8'h00);
    edge_case(1'b0, 8'h40);
    for (int i = 0; i < 4; i++) edge_case(1'b1, bmode[i]);
    $display("test pin edges done");
    bus(1'b1, mtu_pkg::IDX_YMODE, 8'h01);
    wr16(mtu_pkg::IDX_TYL, 16'h0800);
    @(posedge clk_sys_i);
    main_run <= 1'b1;
    repeat (400) @(posedge clk_sys_i);
    set_pin(1'b1, 1'b1);
    rd16(mtu_pkg::IDX_TYL);
    h = r16;
    `CHK(h < 16'h0800, 1'b1, "captured value before reload")
    rd16(mtu_pkg::IDX_TYL);
    `CHK(r16 > h && r16 <= 16'h0800, 1'b1, "counter reloaded on edge")
    main_run <= 1'b0;
    $display("test period mode done");
    // Timer 2 counts timer 1 underflows; all three are rewritten after the source change.
    a = 8'h01 + 8'($urandom % 4);
    bus(1'b1, mtu_pkg::IDX_T123, 8'h04);
    bus(1'b1, mtu_pkg::IDX_T1, 8'h01);
    bus(1'b1, mtu_pkg::IDX_T2, a);
    bus(1'b1, mtu_pkg::IDX_T3, 8'hFF);
    bus(1'b1, mtu_pkg::IDX_XMODE, 8'h01);
    wr16(mtu_pkg::IDX_TXL, 16'h0001);
    `CHK(pin_a_oe, 1'b1, "pulse output pin enabled")
    `CHK(pin_a_drv, 1'b0, "pulse output idle")
    bus(1'b1, mtu_pkg::IDX_REQ, 8'hFF);
    @(posedge clk_sys_i);
    main_run <= 1'b1;
    wait_irq(mtu_pkg::RQ_X, 300);
    `CHK(pin_a_drv, 1'b1, "pulse output toggled at underflow")
    `CHK(irq[mtu_pkg::RQ_T1], 1'b1, "timer 1 underflow request")
    bus(1'b0, mtu_pkg::IDX_T2, 8'h00);
    `CHK(q, a - 8'h01, "timer 2 clocked by timer 1 underflow")
    wait_irq(mtu_pkg::RQ_T2, 600);
    `CHK(pin_a_drv, ~a[0], "pulse output toggles every underflow")
    main_run <= 1'b0;
    $display("test chained timers done");
    print_verdict();
  end
endmodule
